// ### src/acs_regs.vh
// Purpose: Constants for the input configuration and sequencer block
// Assumes: 16-bit host frames, selector in the top five bits
// Notes:   Definitions only
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
// ==========================================================
// Frame layout
`define ACS_FRAME_BITS 5'd16
`define ACS_SEL_HI 15
`define ACS_SEL_LO 11
`define ACS_PAIR_HI 10
`define ACS_PAIR_LO 3
`define ACS_COM_BIT 2
// ==========================================================
// Register selector codes
`define ACS_SEL_UNI 5'b10001
`define ACS_SEL_BIP 5'b10010
`define ACS_SEL_SPAN 5'b10011
`define ACS_SEL_SCAN_HI 5'b10100
`define ACS_SEL_SCAN_LO 5'b10101
`define ACS_SEL_SEQ 5'b10110
// ==========================================================
// Reset values
`define ACS_PAIR_RST 8'h00
`define ACS_MASK_RST 16'h0000
// ==========================================================
// Negative input source codes
`define ACS_NEG_GND 2'h0
`define ACS_NEG_PAIR 2'h1
`define ACS_NEG_COM 2'h2
// ==========================================================
// Sequence sizes
`define ACS_SEQ_DEPTH 256
`define ACS_NIB_LAST 2'h3
`endif

// ### src/acs_top.v
// Purpose: Input span/config decode and programmable channel sequencer
// Assumes: Serial clock well below clock_i/4; data sampled on its rise
// Notes:   Register writes commit on chip-select release
//
// Contract
// - Span selector code writes only span register
// - Span bit per pair, 0 half, 1 double
// - Span applies only to bipolar pairs
// - Single channel select used outside custom mode while no sequence runs
// - Custom mode uses the 16-bit scan mask
// - All bits zero: single-ended, binary coding
// - Only bipolar set: pair, two's complement
// - Unipolar set wins: pair, binary coding
// - Common mode: input against last pin, binary
// - Same decode for every pair
// - Sequence holds up to 256 entries
// - Entries stored as 4-bit channel nibbles
// - New pattern active by next select fall
// - Missing nibbles fill with channel 0
// - Excess nibbles ignored until select rises
// - Partial nibble stored as channel 0
// - Start runs from first sequence entry
// - Shutdown during last readout is safe
// - Unipolar selector code writes unipolar bits
// - Bipolar selector code writes bipolar bits
// - Common mode bit is bit 2
// - Scan selectors write upper/lower mask halves
`include "acs_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module acs_top (
    // Clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // Serial host pins
    input wire cs_n_i,
    input wire sclk_i,
    input wire din_i,
    // Mode control from the scan controller
    input wire custom_mode_i,
    input wire [3:0] single_channel_select_i,
    // Sequencer control
    input wire seq_start_i,
    input wire seq_next_i,
    input wire shutdown_req_i,
    // Conversion setup
    output reg [15:0] chan_enable_o,
    output reg [3:0] conv_pos_o,
    output reg [1:0] conv_neg_o,
    output reg conv_twos_o,
    output reg conv_span_o,
    // Sequencer status
    output reg seq_active_o,
    output reg [7:0] seq_index_o,
    output reg seq_last_o,
    output reg shutdown_o
);

    // ==========================================================
    // Pin synchronisers
    reg [1:0] cs_sync_q;  // Chip select, two stages
    reg [1:0] sck_sync_q; // Serial clock, two stages
    reg [1:0] din_sync_q; // Data, two stages
    reg cs_prev_q;        // Last settled chip select
    reg sck_prev_q;       // Last settled serial clock

    // Second stage feeds the edge detectors and the data sample
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            cs_sync_q <= 2'h3;
            sck_sync_q <= 2'h0;
            din_sync_q <= 2'h0;
            cs_prev_q <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], cs_n_i};
            sck_sync_q <= {sck_sync_q[0], sclk_i};
            din_sync_q <= {din_sync_q[0], din_i};
            cs_prev_q <= cs_sync_q[1];
            sck_prev_q <= sck_sync_q[1];
        end
    end

    wire cs_fall = cs_prev_q & ~cs_sync_q[1];  // Frame begins
    wire cs_rise = ~cs_prev_q & cs_sync_q[1];  // Frame ends
    wire bit_stb = ~cs_sync_q[1] & ~sck_prev_q & sck_sync_q[1];
    wire din_s = din_sync_q[1];

    // ==========================================================
    // Frame receiver
    reg [15:0] shift_q;     // Incoming frame, MSB first
    reg [4:0] bit_cnt_q;    // Saturates at a full frame
    reg pat_expect_q;       // Next frame carries the pattern
    reg pat_frame_q;        // Current frame is a pattern frame
    reg [1:0] nib_cnt_q;    // Bits held of the current nibble
    reg [2:0] nib_q;        // Leading bits of the nibble
    reg [8:0] wr_idx_q;     // Next entry to write
    reg [7:0] len_pend_q;   // Length minus one, awaiting pattern
    reg [7:0] len_act_q;    // Length minus one, in use
    reg seq_loaded_q;       // A pattern has been loaded
    reg [7:0] uni_q;        // Unipolar bit per pair, index = pair
    reg [7:0] bip_q;        // Bipolar bit per pair
    reg [7:0] span_q;       // Span bit per pair
    reg com_q;              // Common reference mode
    reg [15:0] mask_q;      // Scan mask, bit n = input n

    wire [4:0] sel = shift_q[`ACS_SEL_HI:`ACS_SEL_LO];
    wire [7:0] field = shift_q[`ACS_PAIR_HI:`ACS_PAIR_LO];
    wire frame_ok = cs_rise & ~pat_frame_q & (bit_cnt_q == `ACS_FRAME_BITS);
    wire nib_done = pat_frame_q & bit_stb & (nib_cnt_q == `ACS_NIB_LAST);
    // Writes stop once the length is used up, the rest is dropped
    wire nib_wr = nib_done & (wr_idx_q <= {1'b0, len_pend_q});
    wire [3:0] nib_val = {nib_q, din_s};
    wire pat_clear = cs_fall & pat_expect_q;

    // Reverses frame bit order so index 0 is the first pair
    function [7:0] acs_rev8;
        input [7:0] v;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                acs_rev8[k] = v[7 - k];
            end
        end
    endfunction

    // Shift and count, register commit on release
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            shift_q <= 16'h0000;
            bit_cnt_q <= 5'h00;
            pat_expect_q <= 1'b0;
            pat_frame_q <= 1'b0;
            nib_cnt_q <= 2'h0;
            nib_q <= 3'h0;
            wr_idx_q <= 9'h000;
            len_pend_q <= 8'h00;
            len_act_q <= 8'h00;
            seq_loaded_q <= 1'b0;
            uni_q <= `ACS_PAIR_RST;
            bip_q <= `ACS_PAIR_RST;
            span_q <= `ACS_PAIR_RST;
            com_q <= 1'b0;
            mask_q <= `ACS_MASK_RST;
        end else begin
            if (cs_fall) begin
                // New frame, counters restart; partial nibbles die here
                bit_cnt_q <= 5'h00;
                nib_cnt_q <= 2'h0;
                pat_frame_q <= pat_expect_q;
                pat_expect_q <= 1'b0;
                if (pat_expect_q) begin
                    wr_idx_q <= 9'h000;
                end
            end else if (bit_stb) begin
                if (bit_cnt_q != `ACS_FRAME_BITS) begin
                    shift_q <= {shift_q[14:0], din_s};
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                end
                nib_q <= {nib_q[1:0], din_s};
                nib_cnt_q <= nib_cnt_q + 2'h1;
                if (nib_done) begin
                    wr_idx_q <= wr_idx_q + 9'h001;
                end
            end
            if (cs_rise & pat_frame_q) begin
                // Pattern takes effect before the next frame starts
                pat_frame_q <= 1'b0;
                len_act_q <= len_pend_q;
                seq_loaded_q <= 1'b1;
            end
            if (frame_ok) begin
                case (sel)
                    `ACS_SEL_SPAN: span_q <= acs_rev8(field);
                    `ACS_SEL_UNI: begin
                        uni_q <= acs_rev8(field);
                        com_q <= shift_q[`ACS_COM_BIT];
                    end
                    `ACS_SEL_BIP: bip_q <= acs_rev8(field);
                    `ACS_SEL_SCAN_HI: mask_q[15:8] <= field;
                    `ACS_SEL_SCAN_LO: mask_q[7:0] <= field;
                    `ACS_SEL_SEQ: begin
                        // Old pattern is dropped; a full reload must follow
                        len_pend_q <= field;
                        pat_expect_q <= 1'b1;
                        seq_loaded_q <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // Sequence storage, flip-flops per entry
    reg [3:0] seq_mem_q [0:`ACS_SEQ_DEPTH-1]; // Channel nibbles

    genvar gi;
    generate
        for (gi = 0; gi < `ACS_SEQ_DEPTH; gi = gi + 1) begin : g_entry
            localparam [8:0] ENT_IDX = gi;                 // This entry's slot number
            // Cleared at pattern start so unwritten entries read channel 0
            always @(posedge clock_i) begin
                if (sys_rst_i | pat_clear) begin
                    seq_mem_q[gi] <= 4'h0;
                end else if (nib_wr && (wr_idx_q == ENT_IDX)) begin
                    seq_mem_q[gi] <= nib_val;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sequence walker
    reg [7:0] rd_idx_q;    // Entry being converted
    reg run_q;             // Sequence running
    reg sd_pend_q;         // Shutdown asked for during the run

    wire at_last = (rd_idx_q == len_act_q);

    // Shutdown waits for the last entry so readout is never cut short
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_idx_q <= 8'h00;
            run_q <= 1'b0;
            sd_pend_q <= 1'b0;
            shutdown_o <= 1'b0;
        end else begin
            if (seq_start_i & seq_loaded_q) begin
                rd_idx_q <= 8'h00;
                run_q <= 1'b1;
                // A request in the start cycle is kept, so setting wins
                sd_pend_q <= shutdown_req_i;
                shutdown_o <= 1'b0;
            end else begin
                if (shutdown_req_i) begin
                    sd_pend_q <= 1'b1;
                end
                if (run_q & seq_next_i) begin
                    if (at_last) begin
                        run_q <= 1'b0;
                        shutdown_o <= sd_pend_q | shutdown_req_i;
                    end else begin
                        rd_idx_q <= rd_idx_q + 8'h01;
                    end
                end else if (~run_q & shutdown_req_i) begin
                    shutdown_o <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Input configuration decode
    reg [3:0] cur_ch;      // Channel being set up
    reg [2:0] pair;        // Its even/odd pair
    reg [3:0] pos_d;
    reg [1:0] neg_d;
    reg twos_d;
    reg span_d;
    reg [15:0] en_d;

    // Same table for every pair, indexed by the pair's own bits
    always @* begin
        cur_ch = run_q ? seq_mem_q[rd_idx_q] : single_channel_select_i;
        pair = cur_ch[3:1];
        en_d = custom_mode_i ? mask_q : (16'h0001 << cur_ch);
        pos_d = cur_ch;
        neg_d = `ACS_NEG_GND;
        twos_d = 1'b0;
        span_d = 1'b0;
        if (com_q) begin
            neg_d = `ACS_NEG_COM;
        end else if (uni_q[pair]) begin
            pos_d = {pair, 1'b0};
            neg_d = `ACS_NEG_PAIR;
        end else if (bip_q[pair]) begin
            pos_d = {pair, 1'b0};
            neg_d = `ACS_NEG_PAIR;
            twos_d = 1'b1;
            span_d = span_q[pair];
        end
        // Otherwise single-ended against ground, binary
    end

    // Registered outputs
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            chan_enable_o <= 16'h0000;
            conv_pos_o <= 4'h0;
            conv_neg_o <= `ACS_NEG_GND;
            conv_twos_o <= 1'b0;
            conv_span_o <= 1'b0;
            seq_active_o <= 1'b0;
            seq_index_o <= 8'h00;
            seq_last_o <= 1'b0;
        end else begin
            chan_enable_o <= en_d;
            conv_pos_o <= pos_d;
            conv_neg_o <= neg_d;
            conv_twos_o <= twos_d;
            conv_span_o <= span_d;
            seq_active_o <= run_q;
            seq_index_o <= rd_idx_q;
            seq_last_o <= run_q & at_last;
        end
    end

endmodule // acs_top

`default_nettype wire

// ### testbench/acs_host_model.sv
// Purpose: Serial host that frames register and sequence writes
// Assumes: Serial clock 160 ns, idles low between frames
// Notes: Data line shows the inverse of its last bit once released
`include "acs_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module acs_host_model (
    // Serial pins toward the block
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o = 1'b0;
    end
    // One frame: top n bits, MSB first; short n models a cut frame
    task send(input logic [15:0] bits, input int n);
        cs_n_o = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            din_o = bits[15 - i];
            #80 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        din_o = ~din_o;
        // Gap covers the synchroniser and commit delay
        #400;
    endtask
    // Length frame first, then the nibble pattern frame
    task load_seq(input logic [7:0] len_m1, input logic [15:0] pat,
        input int n);
        send({`ACS_SEL_SEQ, len_m1, 3'h0}, 16);
        send(pat, n);
    endtask
endmodule // acs_host_model
`default_nettype wire

// ### testbench/acs_top_asserts.sv
// Purpose: Port-level checks of the config decode and sequencer
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound onto every acs_top instance
`include "acs_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module acs_top_asserts (
    // Clock, reset and controls
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic custom_mode_i,
    input wire logic seq_start_i,
    input wire logic seq_next_i,
    input wire logic shutdown_req_i,
    // Watched outputs
    input wire logic [15:0] chan_enable_o,
    input wire logic [3:0] conv_pos_o,
    input wire logic [1:0] conv_neg_o,
    input wire logic conv_twos_o,
    input wire logic conv_span_o,
    input wire logic seq_active_o,
    input wire logic [7:0] seq_index_o,
    input wire logic seq_last_o,
    input wire logic shutdown_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // ====
    // Shutdown asked for while the final entry is handed over
    sequence s_final_req;
        seq_last_o && seq_next_i && shutdown_req_i;
    endsequence
    // Shutdown shows one edge on, the active flag drops one edge later
    sequence s_shut_down;
        shutdown_o ##1 !seq_active_o;
    endsequence
    a_final_shutdown: assert property (s_final_req |=> s_shut_down)
        else $error("shutdown not entered after last entry");
    // ====
    // Coding follows the input configuration
    a_twos_pair: assert property (conv_twos_o |-> conv_neg_o == `ACS_NEG_PAIR)
        else $error("two's complement outside a pair");
    a_span_bipolar: assert property (conv_span_o |-> conv_twos_o)
        else $error("span doubled on a non-bipolar input");
    a_common_binary: assert property (conv_neg_o == `ACS_NEG_COM |-> !conv_twos_o)
        else $error("common reference not binary");
    a_pair_even: assert property (conv_neg_o == `ACS_NEG_PAIR |-> !conv_pos_o[0])
        else $error("pair positive input not even");
    // ====
    // Sequencer stepping; the index only moves on an accepted pulse
    // Status outputs trail the walker by one register stage
    a_start_first: assert property ($rose(seq_active_o) |->
        seq_index_o == 8'h00 && $past(seq_start_i, 2))
        else $error("sequence did not start at entry 0");
    a_next_step: assert property (seq_active_o && seq_next_i && !seq_last_o
        |=> ##1 seq_index_o == $past(seq_index_o, 2) + 8'h01)
        else $error("index did not advance by one");
    a_last_stop: assert property (seq_last_o && seq_next_i |=> ##1 !seq_active_o)
        else $error("sequence ran past last entry");
    a_last_active: assert property (seq_last_o |-> seq_active_o)
        else $error("last flag while idle");
    a_entry_onehot: assert property (seq_active_o && $past(seq_active_o)
        && !custom_mode_i |-> $onehot(chan_enable_o))
        else $error("sequence entry not a single channel");
endmodule // acs_top_asserts
bind acs_top acs_top_asserts u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .custom_mode_i(custom_mode_i), .seq_start_i(seq_start_i), .seq_next_i(seq_next_i),
    .shutdown_req_i(shutdown_req_i), .chan_enable_o(chan_enable_o), .conv_pos_o(conv_pos_o),
    .conv_neg_o(conv_neg_o), .conv_twos_o(conv_twos_o), .conv_span_o(conv_span_o),
    .seq_active_o(seq_active_o), .seq_index_o(seq_index_o), .seq_last_o(seq_last_o),
    .shutdown_o(shutdown_o));
`default_nettype wire

// ### testbench/acs_top_tb.sv
// Purpose: Directed test of span/config decode and sequencer
// Assumes: Host model drives the serial pins
// Notes: Controls change on the falling clock edge
`include "acs_regs.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module acs_top_tb;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic custom_mode_i = 1'b0;
    logic [3:0] single_channel_select_i = 4'h0;
    logic seq_start_i = 1'b0;
    logic seq_next_i = 1'b0;
    logic shutdown_req_i = 1'b0;
    wire cs_n, sclk, din, conv_twos_o, conv_span_o, seq_active_o, seq_last_o, shutdown_o;
    wire [15:0] chan_enable_o;
    wire [3:0] conv_pos_o;
    wire [1:0] conv_neg_o;
    wire [7:0] seq_index_o;
    int checks = 0;
    int n_errors = 0;
    logic [2:0] tbl [5] = '{3'b000, 3'b001, 3'b100, 3'b101, 3'b111}; // uni, com, bip
    logic [3:0] ent [4];
    always #10 clock_i = ~clock_i;
    acs_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
    acs_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .custom_mode_i(custom_mode_i),
        .single_channel_select_i(single_channel_select_i),
        .seq_start_i(seq_start_i), .seq_next_i(seq_next_i), .shutdown_req_i(shutdown_req_i),
        .chan_enable_o(chan_enable_o), .conv_pos_o(conv_pos_o), .conv_neg_o(conv_neg_o),
        .conv_twos_o(conv_twos_o), .conv_span_o(conv_span_o), .seq_active_o(seq_active_o),
        .seq_index_o(seq_index_o), .seq_last_o(seq_last_o), .shutdown_o(shutdown_o));
    // ====
    // Closing verdict, shared with the watchdog
    task test_done;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One-cycle pulse of {shutdown, next, start}; results settle two edges on
    task pulse(input logic [2:0] m);
        @(negedge clock_i) {shutdown_req_i, seq_next_i, seq_start_i} = m;
        @(negedge clock_i) {shutdown_req_i, seq_next_i, seq_start_i} = 3'h0;
        repeat (2) @(negedge clock_i);
    endtask
    // Expected decode worked out from the pair and common bits
    task chk_dec(input logic [3:0] ch, input logic u, c, b);
        logic pr;
        pr = !c && (u || b);
        `CHK(conv_pos_o, (pr ? {ch[3:1], 1'b0} : ch))
        `CHK(conv_neg_o, c ? `ACS_NEG_COM : (pr ? `ACS_NEG_PAIR : `ACS_NEG_GND))
        `CHK(conv_twos_o, pr && !u)
        `CHK(conv_span_o, pr && !u)
        `CHK(chan_enable_o, 16'h0001 << ch)
    endtask
    // Run a loaded sequence, asking for shutdown on its last entry
    task run_seq(input int len);
        pulse(3'b001);
        `CHK(shutdown_o, 1'b0)
        for (int i = 0; i < len; i++) begin
            `CHK(seq_index_o, i[7:0])
            `CHK(chan_enable_o, 16'h0001 << ent[i])
            `CHK(seq_last_o, i == len - 1)
            pulse((i == len - 1) ? 3'b110 : 3'b010);
        end
        `CHK(({seq_active_o, shutdown_o}), 2'b01)
    endtask
    initial begin
        #500000;
        n_errors++;
        test_done;
    end
    initial begin
        logic [7:0] f;
        repeat (6) @(negedge clock_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        `CHK(({seq_active_o, shutdown_o, conv_twos_o, conv_span_o, conv_neg_o}), 6'h00)
        // Each mode on its own pair, span bit always set
        for (int k = 0; k < 5; k++) begin
            f = 8'h80 >> (k + 1);
            single_channel_select_i = 4'((k + 1) * 2 + k % 2);
            host.send({`ACS_SEL_UNI, tbl[k][2] ? f : 8'h00, tbl[k][1], 2'h0}, 16);
            host.send({`ACS_SEL_BIP, tbl[k][0] ? f : 8'h00, 3'h0}, 16);
            host.send({`ACS_SEL_SPAN, f, 3'h0}, 16);
            chk_dec(single_channel_select_i, tbl[k][2], tbl[k][1], tbl[k][0]);
        end
        // Cut frame and unknown selector leave the setup alone
        host.send({`ACS_SEL_UNI, 8'h00, 3'h0}, 10);
        host.send({5'h1f, 8'h00, 3'h0}, 16);
        chk_dec(single_channel_select_i, 1'b1, 1'b1, 1'b1);
        host.send({`ACS_SEL_SCAN_HI, 8'ha5, 3'h0}, 16);
        host.send({`ACS_SEL_SCAN_LO, 8'h3c, 3'h0}, 16);
        @(negedge clock_i) custom_mode_i = 1'b1;
        repeat (4) @(negedge clock_i);
        `CHK(chan_enable_o, 16'ha53c)
        custom_mode_i = 1'b0;
        // Start is refused with no pattern loaded; idle shutdown is taken at once
        pulse(3'b101);
        `CHK(({seq_active_o, shutdown_o}), 2'b01)
        // Two whole nibbles plus a partial one, length four
        host.load_seq(8'h03, 16'h35c0, 10);
        ent = '{4'h3, 4'h5, 4'h0, 4'h0};
        run_seq(4);
        // Reload shorter; excess nibbles dropped
        host.load_seq(8'h01, 16'h9aff, 16);
        ent = '{4'h9, 4'ha, 4'h0, 4'h0};
        run_seq(2);
        test_done;
    end
endmodule // acs_top_tb
`default_nettype wire
